// >>> hw/gqs_params.svh
// Constants for the pin-query and volatile-settings command block.
// Assumes 64-byte reports carried one byte per accepted transfer.
`ifndef GQS_PARAMS_SVH
`define GQS_PARAMS_SVH

// ********************************************************************
// Command codes and fixed answer bytes
// ********************************************************************
`define GQS_CMD_QUERY     8'h51
`define GQS_CMD_SETTINGS  8'h60
`define GQS_ANS_SUCCESS   8'h00
`define GQS_MARK_VALUE    8'hEE
`define GQS_MARK_DIR      8'hEF
`define GQS_FILL          8'h00

// ********************************************************************
// Report layout
// ********************************************************************
`define GQS_LAST_IDX      6'h3F
`define GQS_IDX_CMD       6'h00
`define GQS_IDX_STATUS    6'h01
`define GQS_IDX_PIN_FIRST 6'h02
`define GQS_IDX_PIN_LAST  6'h09
`define GQS_IDX_CLK       6'h02
`define GQS_IDX_DACREF    6'h03
`define GQS_IDX_DACVAL    6'h04
`define GQS_LOAD_BIT      7

// ********************************************************************
// Power-up values of the working settings
// ********************************************************************
`define GQS_RST_DUTY      2'h2
`define GQS_RST_DIV       3'h1
`define GQS_RST_VRM_LVL   2'h0
`define GQS_RST_REF_VRM   1'h0
`define GQS_RST_DAC_VAL   5'h00

`endif

// >>> hw/gqs_pkg.sv
// Types shared by the command block.
// Assumes nothing beyond a SystemVerilog compiler.
package gqs_pkg;

  // ******************************************************************
  // Command sequencer states, Gray along idle, receive, send
  // ******************************************************************
  typedef enum logic [1:0] {
    GQS_IDLE = 2'h0,
    GQS_RECV = 2'h1,
    GQS_SEND = 2'h3
  } gqs_state_type;

endpackage

// >>> hw/gqs_sync.sv
// Three-stage input synchroniser with agreement filter for pin levels.
// Assumes asynchronous pin inputs and a single clk domain.
`timescale 1ns/1ps

module gqs_sync (
  clk,
  rstn,
  pin_async,
  pin_level
);
  input  wire logic       clk;
  input  wire logic       rstn;
  input  wire logic [3:0] pin_async;
  output      logic [3:0] pin_level;

  logic [3:0] s1_ff;
  logic [3:0] s2_ff;
  logic [3:0] s3_ff;
  logic [3:0] lvl_ff;
  logic [3:0] nxt_lvl;

  // ******************************************************************
  // Per-pin stages; a change counts once stage two and three agree
  // ******************************************************************
  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1) begin : g_pin
      always_comb begin
        nxt_lvl[i] = (s2_ff[i] == s3_ff[i]) ? s3_ff[i] : lvl_ff[i];
      end
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          s1_ff[i]  <= 1'b0;
          s2_ff[i]  <= 1'b0;
          s3_ff[i]  <= 1'b0;
          lvl_ff[i] <= 1'b0;
        end else begin
          s1_ff[i]  <= pin_async[i];
          s2_ff[i]  <= s1_ff[i];
          s3_ff[i]  <= s2_ff[i];
          lvl_ff[i] <= nxt_lvl[i];
        end
      end
    end
  endgenerate

  assign pin_level = lvl_ff;

endmodule

// >>> hw/gqs_cmd.sv
// Command interpreter for the pin-query and volatile-settings reports.
// Assumes 64-byte reports arrive byte by byte, aligned from reset onward.
//
// Notes on behaviour
// [R1] Host starts a pin query with code 0x51 in byte zero; other bytes ignored.
// [R2] Query answer echoes 0x51, then 0x00 success; bytes ten onward are filler.
// [R3] General-purpose pins report sampled level 0 or 1 in bytes 2,4,6,8.
// [R4] Pins not in general-purpose mode report 0xEE in their value byte.
// [R5] Direction sits in bytes 3,5,7,9: 0 output, 1 input.
// [R6] Pins not in general-purpose mode report 0xEF in their direction byte.
// [R7] Settings report carries code 0x60 in byte zero; byte one ignored.
// [R8] Settings live only in working flops, restored by reset only.
// [R9] Byte two bit 7 set loads its low five bits, else kept.
// [R10] Byte two bits 4:3 give duty 0, 25, 50 or 75 percent.
// [R11] Byte two bits 2:0 give the clock divider selection on load.
// [R12] Byte three bit 7 set loads its low three bits as DAC reference.
// [R13] Reference bits 2:1: 11 4.096V, 10 2.048V, 01 1.024V, 00 off.
// [R14] Reference bit 0 picks internal reference module, else supply.
// [R15] Byte four bit 7 set loads bits 4:0 as DAC code, else kept.
// [R16] Don't-care bits of bytes two, three, four affect nothing.
// [R17] Exactly one 64-byte answer per pin query, on the same stream.
`timescale 1ns/1ps
`include "gqs_params.svh"

module gqs_cmd (
  clk,
  rstn,
  rx_valid,
  rx_ready,
  rx_data,
  tx_valid,
  tx_ready,
  tx_data,
  tx_last,
  gp_pin_async,
  gp_is_gpio,
  gp_dir_input,
  clk_out_duty,
  clk_out_div,
  dac_vrm_level,
  dac_ref_vrm,
  dac_value
);
  input  wire logic       clk;
  input  wire logic       rstn;
  input  wire logic       rx_valid;
  output      logic       rx_ready;
  input  wire logic [7:0] rx_data;
  output      logic       tx_valid;
  input  wire logic       tx_ready;
  output      logic [7:0] tx_data;
  output      logic       tx_last;
  input  wire logic [3:0] gp_pin_async;
  input  wire logic [3:0] gp_is_gpio;
  input  wire logic [3:0] gp_dir_input;
  output      logic [1:0] clk_out_duty;
  output      logic [2:0] clk_out_div;
  output      logic [1:0] dac_vrm_level;
  output      logic       dac_ref_vrm;
  output      logic [4:0] dac_value;

  gqs_pkg::gqs_state_type state_ff;
  gqs_pkg::gqs_state_type nxt_state;
  logic [5:0]             idx_ff;
  logic [5:0]             nxt_idx;
  logic [7:0]             cmd_ff;
  logic [7:0]             nxt_cmd;
  logic [7:0]             tx_data_ff;
  logic [7:0]             nxt_tx_data;
  logic [3:0]             snap_lvl_ff;
  logic [3:0]             snap_gpio_ff;
  logic [3:0]             snap_dir_ff;
  logic [3:0]             nxt_snap_lvl;
  logic [3:0]             nxt_snap_gpio;
  logic [3:0]             nxt_snap_dir;
  logic [1:0]             duty_ff;
  logic [2:0]             div_ff;
  logic [1:0]             vrm_lvl_ff;
  logic                   ref_vrm_ff;
  logic [4:0]             dac_val_ff;
  logic [1:0]             nxt_duty;
  logic [2:0]             nxt_div;
  logic [1:0]             nxt_vrm_lvl;
  logic                   nxt_ref_vrm;
  logic [4:0]             nxt_dac_val;
  logic [3:0]             pin_level;
  logic                   rx_take;
  logic                   tx_take;
  logic [7:0]             cur_cmd;

  // ******************************************************************
  // Pin level synchroniser
  // ******************************************************************
  gqs_sync u_sync (
    .clk       (clk),
    .rstn      (rstn),
    .pin_async (gp_pin_async),
    .pin_level (pin_level)
  );

  // ******************************************************************
  // Answer byte builder
  // ******************************************************************
  function automatic logic [7:0] answer_byte(
    input logic [5:0] idx,
    input logic [3:0] lvl,
    input logic [3:0] gpio,
    input logic [3:0] dir
  );
    logic [5:0] rel;
    logic [1:0] pin;
    rel = idx - `GQS_IDX_PIN_FIRST;
    pin = rel[2:1];
    if (idx == `GQS_IDX_CMD) begin
      answer_byte = `GQS_CMD_QUERY;                        // see [R2]
    end else if (idx == `GQS_IDX_STATUS) begin
      answer_byte = `GQS_ANS_SUCCESS;                      // see [R2]
    end else if (idx > `GQS_IDX_PIN_LAST) begin
      answer_byte = `GQS_FILL;                             // see [R2]
    end else if (rel[0] == 1'b0) begin
      if (gpio[pin]) begin
        answer_byte = {7'h00, lvl[pin]};                   // see [R3]
      end else begin
        answer_byte = `GQS_MARK_VALUE;                     // see [R4]
      end
    end else begin
      if (gpio[pin]) begin
        answer_byte = {7'h00, dir[pin]};                   // see [R5]
      end else begin
        answer_byte = `GQS_MARK_DIR;                       // see [R6]
      end
    end
  endfunction

  // ******************************************************************
  // Report sequencer
  // ******************************************************************
  assign rx_ready = (state_ff != gqs_pkg::GQS_SEND);
  assign tx_valid = (state_ff == gqs_pkg::GQS_SEND);
  assign tx_last  = tx_valid && (idx_ff == `GQS_LAST_IDX);
  assign rx_take  = rx_valid && rx_ready;
  assign tx_take  = tx_valid && tx_ready;
  assign cur_cmd  = (idx_ff == `GQS_IDX_CMD) ? rx_data : cmd_ff;

  always_comb begin
    nxt_state     = state_ff;
    nxt_idx       = idx_ff;
    nxt_cmd       = cmd_ff;
    nxt_tx_data   = tx_data_ff;
    nxt_snap_lvl  = snap_lvl_ff;
    nxt_snap_gpio = snap_gpio_ff;
    nxt_snap_dir  = snap_dir_ff;
    case (state_ff)
      gqs_pkg::GQS_IDLE: begin
        if (rx_take) begin
          nxt_cmd   = rx_data;                             // see [R1]
          nxt_idx   = 6'h01;
          nxt_state = gqs_pkg::GQS_RECV;
        end
      end
      gqs_pkg::GQS_RECV: begin
        if (rx_take) begin
          nxt_idx = idx_ff + 6'h01;
          if (idx_ff == `GQS_LAST_IDX) begin
            nxt_state = gqs_pkg::GQS_IDLE;
            if (cmd_ff == `GQS_CMD_QUERY) begin
              // Snapshot keeps the whole answer consistent
              nxt_snap_lvl  = pin_level;
              nxt_snap_gpio = gp_is_gpio;
              nxt_snap_dir  = gp_dir_input;
              nxt_tx_data   = `GQS_CMD_QUERY;
              nxt_state     = gqs_pkg::GQS_SEND;             // see [R17]
            end
          end
        end
      end
      gqs_pkg::GQS_SEND: begin
        if (tx_take) begin
          nxt_idx     = idx_ff + 6'h01;
          nxt_tx_data = answer_byte(idx_ff + 6'h01, snap_lvl_ff, snap_gpio_ff,
                                    snap_dir_ff);
          if (idx_ff == `GQS_LAST_IDX) begin
            nxt_state = gqs_pkg::GQS_IDLE;                 // see [R17]
          end
        end
      end
      default: begin
        nxt_state = gqs_pkg::GQS_IDLE;
        nxt_idx   = 6'h00;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_ff     <= gqs_pkg::GQS_IDLE;
      idx_ff       <= 6'h00;
      cmd_ff       <= 8'h00;
      tx_data_ff   <= 8'h00;
      snap_lvl_ff  <= 4'h0;
      snap_gpio_ff <= 4'h0;
      snap_dir_ff  <= 4'h0;
    end else begin
      state_ff     <= nxt_state;
      idx_ff       <= nxt_idx;
      cmd_ff       <= nxt_cmd;
      tx_data_ff   <= nxt_tx_data;
      snap_lvl_ff  <= nxt_snap_lvl;
      snap_gpio_ff <= nxt_snap_gpio;
      snap_dir_ff  <= nxt_snap_dir;
    end
  end

  assign tx_data = tx_data_ff;

  // ******************************************************************
  // Working settings, applied as their bytes arrive
  // ******************************************************************
  always_comb begin
    nxt_duty    = duty_ff;
    nxt_div     = div_ff;
    nxt_vrm_lvl = vrm_lvl_ff;
    nxt_ref_vrm = ref_vrm_ff;
    nxt_dac_val = dac_val_ff;
    if (rx_take && (cur_cmd == `GQS_CMD_SETTINGS)) begin  // see [R7]
      case (idx_ff)
        `GQS_IDX_CLK: begin
          if (rx_data[`GQS_LOAD_BIT]) begin                // see [R9]
            nxt_duty = rx_data[4:3];                       // see [R10]
            nxt_div  = rx_data[2:0];                       // see [R11]
          end
        end
        `GQS_IDX_DACREF: begin
          if (rx_data[`GQS_LOAD_BIT]) begin                // see [R12]
            nxt_vrm_lvl = rx_data[2:1];                    // see [R13]
            nxt_ref_vrm = rx_data[0];                      // see [R14]
          end
        end
        `GQS_IDX_DACVAL: begin
          if (rx_data[`GQS_LOAD_BIT]) begin                // see [R15]
            nxt_dac_val = rx_data[4:0];                    // see [R16]
          end
        end
        default: begin
          nxt_dac_val = dac_val_ff;
        end
      endcase
    end
  end

  // Only reset restores the power-up values
  always_ff @(posedge clk or negedge rstn) begin          // see [R8]
    if (!rstn) begin
      duty_ff    <= `GQS_RST_DUTY;
      div_ff     <= `GQS_RST_DIV;
      vrm_lvl_ff <= `GQS_RST_VRM_LVL;
      ref_vrm_ff <= `GQS_RST_REF_VRM;
      dac_val_ff <= `GQS_RST_DAC_VAL;
    end else begin
      duty_ff    <= nxt_duty;
      div_ff     <= nxt_div;
      vrm_lvl_ff <= nxt_vrm_lvl;
      ref_vrm_ff <= nxt_ref_vrm;
      dac_val_ff <= nxt_dac_val;
    end
  end

  assign clk_out_duty  = duty_ff;
  assign clk_out_div   = div_ff;
  assign dac_vrm_level = vrm_lvl_ff;
  assign dac_ref_vrm   = ref_vrm_ff;
  assign dac_value     = dac_val_ff;

endmodule

// >>> test/gqs_cmd_monitor.sv
// Port checker for the command block.
// Assumes a bind onto gqs_cmd with one clock domain.
`timescale 1ns/1ps

module gqs_cmd_monitor (
  input wire logic       clk,
  input wire logic       rstn,
  input wire logic       rx_valid,
  input wire logic       rx_ready,
  input wire logic       tx_valid,
  input wire logic       tx_ready,
  input wire logic [7:0] tx_data,
  input wire logic       tx_last,
  input wire logic [1:0] clk_out_duty,
  input wire logic [2:0] clk_out_div,
  input wire logic [1:0] dac_vrm_level,
  input wire logic       dac_ref_vrm,
  input wire logic [4:0] dac_value
);
  logic [5:0] cnt_ff;
  logic [5:0] nxt_cnt;

  // Counts answer bytes taken by the host
  always_comb nxt_cnt = (tx_valid && tx_ready) ? cnt_ff + 6'h01 : cnt_ff;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) cnt_ff <= 6'h00;
    else cnt_ff <= nxt_cnt;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  a_answer_head: assert property ($rose(tx_valid) |->
    tx_data == 8'h51 && cnt_ff == 6'h00)
    else $error("answer does not start with the query code");
  a_status_byte: assert property (tx_valid && cnt_ff == 6'h01 |-> tx_data == 8'h00)
    else $error("answer status byte wrong");
  a_value_byte: assert property (tx_valid && cnt_ff inside {2, 4, 6, 8}
    |-> tx_data inside {8'h00, 8'h01, 8'hEE})
    else $error("pin value byte out of range");
  a_dir_byte: assert property (tx_valid && cnt_ff inside {3, 5, 7, 9}
    |-> tx_data inside {8'h00, 8'h01, 8'hEF})
    else $error("pin direction byte out of range");
  a_filler_zero: assert property (tx_valid && cnt_ff > 6'h09 |-> tx_data == 8'h00)
    else $error("filler byte not zero");
  a_last_mark: assert property (tx_valid |-> tx_last == (cnt_ff == 6'h3F))
    else $error("last flag misplaced");
  a_answer_end: assert property (tx_last && tx_ready |=> !tx_valid && rx_ready)
    else $error("answer longer than one report");
  a_rx_closed: assert property (tx_valid |-> !rx_ready)
    else $error("input open during answer");
  a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("answer byte changed while stalled");
  a_settings_hold: assert property (!(rx_valid && rx_ready) |=>
    $stable({clk_out_duty, clk_out_div, dac_vrm_level, dac_ref_vrm, dac_value}))
    else $error("settings moved without input");

  c_answer_done: cover property (tx_last && tx_ready);
  c_answer_stall: cover property (tx_valid && !tx_ready);
  c_dac_load: cover property ($changed(dac_value));
endmodule

// >>> test/gqs_host.sv
// Host model: sends 64-byte reports and takes 64-byte answers.
// Assumes the device byte streams of gqs_cmd on one clock.
`timescale 1ns/1ps

module gqs_host (
  input  wire logic       clk,
  input  wire logic       rx_ready,
  output      logic       rx_valid,
  output      logic [7:0] rx_data,
  output      logic       tx_ready,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data
);
  logic [7:0] ans [0:63];

  initial begin
    rx_valid = 1'b0;
    rx_data  = 8'h00;
    tx_ready = 1'b0;
  end

  // Unused bytes carry noise the device must ignore
  task automatic send(input logic [7:0] b0, b2, b3, b4);
    for (int i = 0; i < 64; i++) begin
      @(negedge clk);
      rx_valid = 1'b1;
      rx_data  = (i == 0) ? b0 : (i == 2) ? b2 : (i == 3) ? b3 :
                 (i == 4) ? b4 : 8'hA5 ^ i[7:0];
      // Ready only moves on a rising edge, so it is settled here
      while (rx_ready !== 1'b1) @(negedge clk);
      @(posedge clk);
    end
    @(negedge clk);
    rx_valid = 1'b0;
    rx_data  = ~rx_data;
  endtask

  // Slow mode takes a byte only every other cycle
  task automatic recv(input bit slow);
    int n;
    n = 0;
    foreach (ans[k]) ans[k] = 8'hXX;
    for (int c = 0; c < 400 && n < 64; c++) begin
      @(negedge clk);
      tx_ready = !slow || c[0];
      // Byte on offer is settled here and is taken at the next rising edge
      if (tx_valid === 1'b1 && tx_ready) begin
        ans[n] = tx_data;
        n++;
      end
      @(posedge clk);
    end
    @(negedge clk);
    tx_ready = 1'b0;
  endtask
endmodule

// >>> test/testbench.sv
// Self-checking bench for the command block.
// Assumes gqs_cmd, the host model and the port checker.
`timescale 1ns/1ps
`include "gqs_params.svh"

module testbench;
  logic        clk, rstn, rx_valid, rx_ready, tx_valid, tx_ready, tx_last, dac_ref_vrm;
  logic [7:0]  rx_data, tx_data;
  logic [3:0]  gp_pin_async, gp_is_gpio, gp_dir_input;
  logic [1:0]  clk_out_duty, dac_vrm_level;
  logic [2:0]  clk_out_div;
  logic [4:0]  dac_value;
  logic [12:0] exp_set;
  wire  [12:0] cur = {clk_out_duty, clk_out_div, dac_vrm_level, dac_ref_vrm, dac_value};
  int          n_fail, check_count;

  gqs_cmd u_gqs_cmd (.clk, .rstn, .rx_valid, .rx_ready, .rx_data, .tx_valid, .tx_ready,
    .tx_data, .tx_last, .gp_pin_async, .gp_is_gpio, .gp_dir_input, .clk_out_duty,
    .clk_out_div, .dac_vrm_level, .dac_ref_vrm, .dac_value);
  gqs_host u_gqs_host (.clk, .rx_ready, .rx_valid, .rx_data, .tx_ready, .tx_valid, .tx_data);

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic t_reset();
    @(negedge clk);
    rstn = 1'b0;
    repeat (6) @(negedge clk);
    rstn = 1'b1;
    exp_set = {`GQS_RST_DUTY, `GQS_RST_DIV, `GQS_RST_VRM_LVL, `GQS_RST_REF_VRM, `GQS_RST_DAC_VAL};
    chk("reset settings", {3'h0, exp_set}, {3'h0, cur});
    $display("test reset done");
  endtask

  task automatic t_set(input logic [7:0] b0, b2, b3, b4);
    if (b0 == `GQS_CMD_SETTINGS) begin
      if (b2[7]) exp_set[12:8] = b2[4:0];
      if (b3[7]) exp_set[7:5] = b3[2:0];
      if (b4[7]) exp_set[4:0] = b4[4:0];
    end
    u_gqs_host.send(b0, b2, b3, b4);
    chk("settings", {3'h0, exp_set}, {3'h0, cur});
    $display("test settings %h %h %h %h done", b0, b2, b3, b4);
  endtask

  task automatic t_query(input logic [3:0] g, d, p, input bit slow);
    logic [7:0] e;
    int         k;
    @(negedge clk);
    gp_is_gpio   = g;
    gp_dir_input = d;
    gp_pin_async = p;
    repeat (6) @(negedge clk);
    u_gqs_host.send(`GQS_CMD_QUERY, 8'h9F, 8'h87, 8'h9F);
    u_gqs_host.recv(slow);
    for (int i = 0; i < 64; i++) begin
      k = (i - 2) / 2;
      e = (i == 0) ? 8'h51 : 8'h00;
      if (i >= 2 && i <= 9 && !g[k]) e = i[0] ? 8'hEF : 8'hEE;
      else if (i >= 2 && i <= 9) e = {7'h00, i[0] ? d[k] : p[k]};
      chk($sformatf("answer byte %0d", i), {8'h00, e}, {8'h00, u_gqs_host.ans[i]});
    end
    repeat (3) @(negedge clk);
    chk("second answer", 16'h0000, {15'h0000, tx_valid});
    chk("settings", {3'h0, exp_set}, {3'h0, cur});
    $display("test query %h done", g);
  endtask

  initial begin
    rstn         = 1'b0;
    gp_pin_async = 4'h0;
    gp_is_gpio   = 4'h0;
    gp_dir_input = 4'h0;
    n_fail       = 0;
    check_count  = 0;
    t_reset();
    t_set(8'h60, 8'hFA, 8'hFB, 8'hFF);
    t_set(8'h60, 8'h7F, 8'h05, 8'h1C);
    t_query(4'hB, 4'h6, 4'hD, 1'b0);
    t_set(8'h60, 8'h81, 8'h86, 8'h80);
    t_query(4'h4, 4'hF, 4'h2, 1'b1);
    t_set(8'h60, 8'h8C, 8'h84, 8'h95);
    t_set(8'h33, 8'hFF, 8'hFF, 8'hFF);
    t_set(8'h60, 8'h97, 8'h82, 8'h00);
    t_reset();
    final_report();
  end

  initial begin
    #(50 * 4000);
    n_fail++;
    final_report();
  end
endmodule

bind gqs_cmd gqs_cmd_monitor u_gqs_cmd_monitor (.clk, .rstn, .rx_valid, .rx_ready, .tx_valid,
  .tx_ready, .tx_data, .tx_last, .clk_out_duty, .clk_out_div, .dac_vrm_level, .dac_ref_vrm,
  .dac_value);
